// *** hw/lane_mask_pkg.sv ***
package lane_mask_pkg;
	// Burst sequencer states
	typedef enum logic [1:0] {
		idle_st,
		beat0_st,
		beat1_st
	} burst_e;
endpackage

// *** hw/lane_mask_regs.svh ***
// Summary of operation
// - Write starts on load low, direction low.
// - Lane selects sampled separately per data beat.
// - 8-bit, both low: write bits 7..0.
// - 8-bit, lane 0 only: write low nibble.
// - 8-bit, lane 1 only: write high nibble.
// - 18-bit, both low: write all eighteen bits.
// - 18-bit, lane 0 only: write bits 8..0.
// - 18-bit, lane 1 only: write bits 17..9.
// - 8/18-bit, both high: nothing written.
// - 9-bit: low writes nine bits, high nothing.
// - 36-bit, all low: write all bits.
// - 36-bit, lane 0 only: bits 8..0.
// - 36-bit, lane 1 only: bits 17..9.
// - 36-bit, lane 2 only: bits 26..18.
// - 36-bit, lane 3 only: bits 35..27.
// - 9/36-bit, all high: word unchanged.
`ifndef LANE_MASK_REGS_SVH
`define LANE_MASK_REGS_SVH
// Default word width and lane count
`define LM_DATA_WIDTH 18
`define LM_LANES 2
// Default address width and buffer depth
`define LM_ADDR_WIDTH 4
`define LM_FIFO_DEPTH 8
`endif

// *** hw/sram_write_lane_mask.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lane_mask_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Small valid/ready FIFO in flip-flops
module lane_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `LM_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];     // Storage
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d; // Pointers
	logic [AW:0] cnt_q, cnt_d;           // Fill level
	logic push, pop;
	// Next pointers and level
	always_comb begin
		// Accept only while a free slot is left
		push = in_valid && (cnt_q != (AW+1)'(DEPTH));
		pop = out_valid && out_ready;
		wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	// Register pointers and fill level
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
	// Storage write, no reset needed
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
endmodule // lane_fifo

////////////////////////////////////////////////////////////////////////////////
// Write lane masking for a two-beat burst memory
module sram_write_lane_mask #(
	parameter int DATA_WIDTH = `LM_DATA_WIDTH,
	parameter int LANES = `LM_LANES,
	parameter int ADDR_WIDTH = `LM_ADDR_WIDTH,
	parameter int FIFO_DEPTH = `LM_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic load_strobe_n,
	input wire logic read_not_write,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic [DATA_WIDTH-1:0] data_in,
	input wire logic [LANES-1:0] byte_lane_enable_n,
	input wire logic [ADDR_WIDTH-1:0] read_address,
	output logic [DATA_WIDTH-1:0] read_data,
	output logic busy
);
	import lane_mask_pkg::*;
	localparam int LW = DATA_WIDTH / LANES; // Lane width
	localparam int EW = ADDR_WIDTH + 1 + DATA_WIDTH + LANES;
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, two stages each
	logic [1+1+ADDR_WIDTH+DATA_WIDTH+LANES-1:0] s1_q, s2_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= {load_strobe_n, read_not_write, address, data_in, byte_lane_enable_n};
			s2_q <= s1_q;
		end
	end
	logic ld_n, rnw;
	logic [ADDR_WIDTH-1:0] addr_s;
	logic [DATA_WIDTH-1:0] data_s;
	logic [LANES-1:0] lane_n_s;
	assign {ld_n, rnw, addr_s, data_s, lane_n_s} = s2_q;
	////////////////////////////////////////////////////////////////////////////
	// Burst sequencer: beat 0 then beat 1 after a write load
	burst_e st_q, st_d;
	logic [ADDR_WIDTH-1:0] base_q, base_d;
	logic beat_v;
	logic [EW-1:0] beat_e;
	always_comb begin
		st_d = st_q;
		base_d = base_q;
		beat_v = 1'b0;
		beat_e = {base_q, 1'b0, data_s, lane_n_s};
		case (st_q)
			idle_st: begin
				if (!ld_n && !rnw) begin
					st_d = beat0_st;
					base_d = addr_s;
				end
			end
			beat0_st: begin
				beat_v = 1'b1; // first beat uses its own selects
				beat_e = {base_q, 1'b0, data_s, lane_n_s};
				st_d = beat1_st;
			end
			beat1_st: begin
				beat_v = 1'b1; // second beat sampled separately
				beat_e = {base_q, 1'b1, data_s, lane_n_s};
				st_d = idle_st;
				if (!ld_n && !rnw) begin
					st_d = beat0_st;
					base_d = addr_s;
				end
			end
			default: st_d = idle_st;
		endcase
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= idle_st;
			base_q <= '0;
		end else begin
			st_q <= st_d;
			base_q <= base_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Beat FIFO between capture and array
	logic f_ready, f_valid;
	logic [EW-1:0] f_data;
	lane_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) beat_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.in_valid(beat_v),
		.in_ready(f_ready),
		.in_data(beat_e),
		.out_valid(f_valid),
		.out_ready(1'b1),
		.out_data(f_data)
	);
	////////////////////////////////////////////////////////////////////////////
	// Array: word address is base with the beat index appended as low bit
	localparam int WORDS = 2 ** (ADDR_WIDTH + 1);
	logic [DATA_WIDTH-1:0] mem_q [WORDS];
	logic [ADDR_WIDTH:0] wa;
	logic [DATA_WIDTH-1:0] wd, merged;
	logic [LANES-1:0] wn;
	assign {wa, wd, wn} = f_data;
	// Per-lane merge: low select takes new data, high keeps old
	always_comb begin
		merged = mem_q[wa];
		for (int i = 0; i < LANES; i++) begin
			if (!wn[i]) begin
				merged[i*LW +: LW] = wd[i*LW +: LW];
			end // lanes with high select keep stored bits
		end
	end
	always_ff @(posedge clock) begin
		if (f_valid) begin
			mem_q[wa] <= merged;
		end
	end
	// Registered read port and status
	logic [DATA_WIDTH-1:0] rd_d;
	logic busy_d;
	always_comb begin
		rd_d = mem_q[{read_address, 1'b0}];
		busy_d = (st_d != idle_st) || f_valid || !f_ready;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= '0;
			busy <= 1'b0;
		end else begin
			read_data <= rd_d;
			busy <= busy_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence wr_load_s;
		!ld_n && !rnw && (st_q != beat0_st);
	endsequence
	burst_start_a: assert property (@(posedge clock) disable iff (!reset_n)
		wr_load_s |=> st_q == beat0_st) else $error("write load did not start burst");
	beat_order_a: assert property (@(posedge clock) disable iff (!reset_n)
		st_q == beat0_st |=> st_q == beat1_st && beat_v) else $error("second beat missing");
	no_burst_a: assert property (@(posedge clock) disable iff (!reset_n)
		st_q == idle_st |-> !beat_v) else $error("beat outside burst");
	lane_write_a: assert property (@(posedge clock) disable iff (!reset_n)
		f_valid && !wn[0] |=> mem_q[$past(wa)][LW-1:0] == $past(wd[LW-1:0]))
		else $error("enabled lane not written");
	lane_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
		f_valid && wn[0] |=> mem_q[$past(wa)][LW-1:0] == $past(mem_q[wa][LW-1:0]))
		else $error("masked lane altered");
	all_masked_a: assert property (@(posedge clock) disable iff (!reset_n)
		f_valid && &wn |-> merged == mem_q[wa]) else $error("masked word altered");
	all_enabled_a: assert property (@(posedge clock) disable iff (!reset_n)
		f_valid && wn == '0 |-> merged == wd) else $error("full word not written");
	top_lane_a: assert property (@(posedge clock) disable iff (!reset_n)
		f_valid && !wn[LANES-1] |-> merged[DATA_WIDTH-1 -: LW] == wd[DATA_WIDTH-1 -: LW])
		else $error("top lane not written");
	// A beat must never be dropped at the buffer input
	beat_lost_a: assert property (@(posedge clock) disable iff (!reset_n)
		beat_v |-> f_ready) else $error("beat dropped at buffer");
	// Second beat carries the odd word of the pair
	beat_word_a: assert property (@(posedge clock) disable iff (!reset_n)
		st_q == beat1_st |-> beat_e[EW-1 -: ADDR_WIDTH+1] == {base_q, 1'b1})
		else $error("second beat has wrong word");
	// First beat carries the even word of the pair
	beat_even_a: assert property (@(posedge clock) disable iff (!reset_n)
		st_q == beat0_st |-> beat_e[EW-1 -: ADDR_WIDTH+1] == {base_q, 1'b0})
		else $error("first beat has wrong word");
	////////////////////////////////////////////////////////////////////////////
	// Width-specific lane tables, checked on the merged word
	generate
		if (LANES == 1) begin : g_one_lane
			// Single select gates the whole word
			one_write_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && !wn[0] |-> merged == wd)
				else $error("single lane not written");
			// High select leaves the word alone
			one_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn[0] |-> merged == mem_q[wa])
				else $error("single lane altered");
		end else if (LANES == 2) begin : g_two_lanes
			// Both selects low: whole word
			pair_both_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 2'b00 |-> merged == wd)
				else $error("pair not fully written");
			// Low lane only
			pair_low_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 2'b10 |-> merged[LW-1:0] == wd[LW-1:0]
				&& merged[DATA_WIDTH-1:LW] == mem_q[wa][DATA_WIDTH-1:LW])
				else $error("low lane write wrong");
			// High lane only
			pair_high_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 2'b01 |-> merged[DATA_WIDTH-1:LW] == wd[DATA_WIDTH-1:LW]
				&& merged[LW-1:0] == mem_q[wa][LW-1:0])
				else $error("high lane write wrong");
			// Both high: nothing changes
			pair_none_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 2'b11 |-> merged == mem_q[wa])
				else $error("masked pair altered");
		end else if (LANES == 4) begin : g_four_lanes
			// All selects low: whole word
			quad_all_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'h0 |-> merged == wd)
				else $error("quad not fully written");
			// Lane 0 only
			quad_lane0_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'he |-> merged[LW-1:0] == wd[LW-1:0]
				&& merged[DATA_WIDTH-1:LW] == mem_q[wa][DATA_WIDTH-1:LW])
				else $error("lane 0 write wrong");
			// Lane 1 only
			quad_lane1_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'hd |-> merged[2*LW-1:LW] == wd[2*LW-1:LW]
				&& merged[LW-1:0] == mem_q[wa][LW-1:0]
				&& merged[DATA_WIDTH-1:2*LW] == mem_q[wa][DATA_WIDTH-1:2*LW])
				else $error("lane 1 write wrong");
			// Lane 2 only
			quad_lane2_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'hb |-> merged[3*LW-1:2*LW] == wd[3*LW-1:2*LW]
				&& merged[2*LW-1:0] == mem_q[wa][2*LW-1:0]
				&& merged[DATA_WIDTH-1:3*LW] == mem_q[wa][DATA_WIDTH-1:3*LW])
				else $error("lane 2 write wrong");
			// Lane 3 only
			quad_lane3_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'h7 |-> merged[DATA_WIDTH-1:3*LW] == wd[DATA_WIDTH-1:3*LW]
				&& merged[3*LW-1:0] == mem_q[wa][3*LW-1:0])
				else $error("lane 3 write wrong");
			// All high: nothing changes
			quad_none_a: assert property (@(posedge clock) disable iff (!reset_n)
				f_valid && wn == 4'hf |-> merged == mem_q[wa])
				else $error("masked quad altered");
		end
	endgenerate
endmodule // sram_write_lane_mask
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for write lane masking
module tb_top;
	logic clock = 1'b0; // 20 MHz clock
	logic reset_n = 1'b0; // Async reset, active low
	logic [3:0] read_address = 4'h0; // Read port address
	logic [17:0] read_data; // Word read back
	logic busy; // Pending work flag
	logic [17:0] exp_q = 18'h00000; // Expected beat 0 word at address 3
	int fail_count = 0;
	int comparisons = 0;
	wire logic load_strobe_n, read_not_write;
	wire logic [3:0] address;
	wire logic [17:0] data_in;
	wire logic [1:0] byte_lane_enable_n;
	// Far-side controller
	write_ctl_model ctl (.clock(clock), .load_strobe_n(load_strobe_n),
		.read_not_write(read_not_write), .address(address), .data_in(data_in),
		.byte_lane_enable_n(byte_lane_enable_n));
	// Block under test
	sram_write_lane_mask dut (.clock(clock), .reset_n(reset_n),
		.load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
		.address(address), .data_in(data_in), .byte_lane_enable_n(byte_lane_enable_n),
		.read_address(read_address), .read_data(read_data), .busy(busy));
	// Clock generator
	initial begin
		forever #25 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task check(input logic [17:0] seen, input logic [17:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Lanes with a low select take new data
	function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] d, logic [1:0] m);
		merge = old;
		for (int i = 0; i < 2; i++) begin
			if (!m[i]) merge[i*9+:9] = d[i*9+:9];
		end
	endfunction
	// One burst to address 3, then read its beat 0 word back
	task run(input logic rw, input logic [17:0] d0, input logic [1:0] m0, m1,
		output logic [17:0] v);
		read_address <= 4'h0;
		ctl.burst(rw, 4'h3, d0, ~d0, m0, m1);
		if (!rw) exp_q = merge(exp_q, d0, m0);
		repeat (12) @(posedge clock);
		read_address <= 4'h3;
		repeat (2) @(posedge clock);
		#1 v = read_data;
		check({17'h00000, busy}, 18'h00000);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_full;
		logic [17:0] v;
		run(1'b0, 18'h2d3c1, 2'h0, 2'h0, v);
		check(v, exp_q);
		$display("test full done");
	endtask
	task t_lane0;
		logic [17:0] v;
		run(1'b0, 18'h3ffff, 2'h2, 2'h0, v);
		check(v, exp_q);
		$display("test lane0 done");
	endtask
	task t_lane1;
		logic [17:0] v;
		run(1'b0, 18'h00000, 2'h1, 2'h2, v);
		check(v, exp_q);
		$display("test lane1 done");
	endtask
	task t_none;
		logic [17:0] v;
		run(1'b0, 18'h15a5a, 2'h3, 2'h0, v);
		check(v, exp_q);
		$display("test none done");
	endtask
	task t_readload;
		logic [17:0] v;
		run(1'b1, 18'h0f0f0, 2'h0, 2'h0, v);
		check(v, exp_q);
		$display("test read load done");
	endtask
	// Verdict and end of run
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#(50 * 2000);
		fail_count++;
		end_sim;
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		t_full;
		t_lane0;
		t_lane1;
		t_none;
		t_readload;
		end_sim;
	end
endmodule // tb_top
`default_nettype wire

// *** verif/write_ctl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// External controller that issues two-beat write bursts
module write_ctl_model (
	input wire logic clock,
	output logic load_strobe_n,
	output logic read_not_write,
	output logic [3:0] address,
	output logic [17:0] data_in,
	output logic [1:0] byte_lane_enable_n
);
	// Idle pin levels
	initial begin
		load_strobe_n = 1'b1;
		read_not_write = 1'b1;
		address = 4'h0;
		data_in = 18'h00000;
		byte_lane_enable_n = 2'h3;
	end
	// Load cycle, then one beat per cycle; lanes may differ per beat
	task burst(input logic rw, input logic [3:0] a, input logic [17:0] d0, d1,
		input logic [1:0] m0, m1);
		@(posedge clock);
		load_strobe_n <= 1'b0;
		read_not_write <= rw;
		address <= a;
		@(posedge clock);
		load_strobe_n <= 1'b1;
		address <= ~a;
		data_in <= d0;
		byte_lane_enable_n <= m0;
		@(posedge clock);
		data_in <= d1;
		byte_lane_enable_n <= m1;
		@(posedge clock);
		// Released lines show the inverse, not the last value
		data_in <= ~d1;
		byte_lane_enable_n <= ~m1;
		read_not_write <= 1'b1;
	endtask
endmodule // write_ctl_model
`default_nettype wire
